// ### fbp_pkg.sv
package fbp_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam logic [15:0] OFS_UNLOCK1 = 16'h0555;
   localparam logic [15:0] OFS_UNLOCK2 = 16'h02aa;
   localparam logic [15:0] CMD_UNLOCK1 = 16'h00aa;
   localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
   localparam logic [15:0] CMD_BUF_LOAD = 16'h0025;
   localparam logic [15:0] CMD_BUF_CONFIRM = 16'h0029;
   localparam logic [15:0] CMD_ABORT_RESET = 16'h00f0;
   localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
   localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
   localparam logic [15:0] CMD_ERASE_SUSPEND = 16'h00b0;
   localparam logic [15:0] ERASED_WORD = 16'hffff;
   localparam int BUF_WORDS = 32;
   localparam int PAGE_LSB = 5;
   localparam int SECTOR_LSB = 12;
   localparam int BANK_LSB = 14;
   localparam int STS_POLL = 7;
   localparam int STS_TOGGLE = 6;
   localparam int STS_LIMIT = 5;
   localparam int STS_TIMER = 3;
   localparam int STS_ETOGGLE = 2;
   localparam int STS_ABORT = 1;
   localparam int CLK_NS = 40;
   localparam int SEA_TIME_US = 50;
   localparam int SEA_CYCLES = (SEA_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int PROG_CYCLES = 64;
   localparam int ERASE_CYCLES_PER_SECTOR = 256;
   localparam int TIMER_W = 16;
   localparam logic [15:0] RESET_WORD = 16'h0000;
endpackage : fbp_pkg

// ### fbp_bus_if.sv
`timescale 1ns/1ps
interface fbp_bus_if;
   logic wr_valid;
   logic wr_ready;
   logic [15:0] wr_addr;
   logic [15:0] wr_data;
   logic rd_req;
   logic [15:0] rd_addr;
   logic rd_valid;
   logic [15:0] rd_data;
   modport host (
      output wr_valid, wr_addr, wr_data, rd_req, rd_addr,
      input wr_ready, rd_valid, rd_data
   );
   modport dev (
      input wr_valid, wr_addr, wr_data, rd_req, rd_addr,
      output wr_ready, rd_valid, rd_data
   );
endinterface : fbp_bus_if

// ### fbp_dev.sv
`timescale 1ns/1ps
module fbp_dev #(
   parameter int SEA_CYC = fbp_pkg::SEA_CYCLES,
   parameter int PROG_CYC = fbp_pkg::PROG_CYCLES,
   parameter int ERASE_CYC = fbp_pkg::ERASE_CYCLES_PER_SECTOR
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host side
   fbp_bus_if.dev bus,
   // Array port: one word write per cycle
   output logic arr_we,
   output logic [15:0] arr_addr,
   output logic [15:0] arr_wdata,
   input wire logic [15:0] arr_rdata,
   // Status
   output logic busy,
   output logic aborted
);
   initial begin
      if (SEA_CYC < 1 || SEA_CYC > 65535 || PROG_CYC < 1 ||
          ERASE_CYC < 1 || ERASE_CYC > 65535) begin
         $error("fbp_dev: timer parameter out of range");
      end
   end

   typedef enum logic [3:0] {
      S_READ = 4'b0000, S_U1 = 4'b0001, S_U2 = 4'b0010,
      S_COUNT = 4'b0011, S_LOAD = 4'b0100, S_CONFIRM = 4'b0101,
      S_PROG = 4'b0110, S_ABORT = 4'b0111, S_AU1 = 4'b1000,
      S_AU2 = 4'b1001, S_E1 = 4'b1010, S_E2 = 4'b1011,
      S_E3 = 4'b1100, S_EWIN = 4'b1101, S_ERASE = 4'b1110,
      S_SUSP = 4'b1111
   } fbp_state_t;

   typedef struct packed {
      fbp_state_t st;
      logic [5:0] left;
      logic [5:0] nwords;
      logic [15:0] sec;
      logic [15:0] last_addr;
      logic [15:0] last_data;
      logic [15:0] timer;
      logic [3:0] sec_mask;
      logic [3:0] sec_idx;
      logic [5:0] wr_idx;
      logic toggle;
      logic etoggle;
      logic page_set;
      logic wr_ready;
      logic rd_valid;
      logic [15:0] rd_data;
      logic arr_we;
      logic [15:0] arr_addr;
      logic [15:0] arr_wdata;
      logic [11:0] word;
      logic busy, aborted;
   } fbp_dev_t;

   fbp_dev_t q, d;
   logic [15:0] buf_data [32];
   logic [31:0] buf_vld;
   logic wr, rd, is_u1, is_u2, in_sec, in_page, erase_bank;
   logic [15:0] sts;

   assign wr = bus.wr_valid & q.wr_ready;
   assign rd = bus.rd_req;
   assign is_u1 = bus.wr_addr == fbp_pkg::OFS_UNLOCK1 &&
                  bus.wr_data == fbp_pkg::CMD_UNLOCK1;
   assign is_u2 = bus.wr_addr == fbp_pkg::OFS_UNLOCK2 &&
                  bus.wr_data == fbp_pkg::CMD_UNLOCK2;
   assign in_sec = bus.wr_addr[15:fbp_pkg::SECTOR_LSB] ==
                   q.sec[15:fbp_pkg::SECTOR_LSB];
   assign in_page = bus.wr_addr[15:fbp_pkg::PAGE_LSB] ==
                    q.last_addr[15:fbp_pkg::PAGE_LSB];
   assign erase_bank = bus.rd_addr[15:fbp_pkg::BANK_LSB] ==
                       q.sec[15:fbp_pkg::BANK_LSB];

   // Buffer storage kept apart from the struct to keep it small
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_vld <= '0;
      end else if (q.st == fbp_state_t'(S_COUNT)) begin
         buf_vld <= '0;
      end else if (q.st == S_LOAD && wr && in_sec &&
                   (!q.page_set || in_page)) begin
         buf_vld[bus.wr_addr[4:0]] <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (q.st == S_LOAD && wr) begin
         buf_data[bus.wr_addr[4:0]] <= bus.wr_data;
      end
   end

   always_comb begin
      d = q;
      d.arr_we = 1'b0;
      d.rd_valid = 1'b0;
      d.wr_ready = 1'b1;
      sts = 16'h0000;
      if (q.timer != 16'h0000) begin
         d.timer = q.timer - 16'h0001;
      end
      case (q.st)
         S_READ: if (wr && is_u1) d.st = S_U1;
         S_U1: if (wr) d.st = is_u2 ? S_U2 : S_READ;
         S_U2: if (wr) begin
            if (bus.wr_data == fbp_pkg::CMD_BUF_LOAD) begin
               d.st = S_COUNT;
               d.sec = bus.wr_addr;
            end else if (bus.wr_addr == fbp_pkg::OFS_UNLOCK1 &&
                         bus.wr_data == fbp_pkg::CMD_ERASE_SETUP) begin
               d.st = S_E1;
            end else begin
               d.st = S_READ;
            end
         end
         S_COUNT: if (wr) begin
            if (bus.wr_data > 16'(fbp_pkg::BUF_WORDS - 1) || !in_sec) begin
               d.st = S_ABORT;
               d.last_addr = bus.wr_addr;
            end else begin
               d.st = S_LOAD;
               d.left = bus.wr_data[5:0] + 6'd1;
               d.nwords = bus.wr_data[5:0] + 6'd1;
               d.page_set = 1'b0;
            end
         end
         S_LOAD: if (wr) begin
            d.last_addr = bus.wr_addr;
            d.last_data = bus.wr_data;
            d.page_set = 1'b1;
            d.left = q.left - 6'd1;
            if (!in_sec || (q.page_set && !in_page)) begin
               d.st = S_ABORT;
            end else if (q.left == 6'd1) begin
               d.st = S_CONFIRM;
            end
         end
         S_CONFIRM: if (wr) begin
            if (bus.wr_data == fbp_pkg::CMD_BUF_CONFIRM && in_sec) begin
               d.st = S_PROG;
               d.wr_ready = 1'b0;
               d.wr_idx = 6'd0;
               d.timer = 16'(PROG_CYC);
            end else begin
               d.st = S_ABORT;
            end
         end
         S_PROG: begin
            d.wr_ready = 1'b0;
            if (q.wr_idx < 6'd32) begin
               d.wr_idx = q.wr_idx + 6'd1;
               if (buf_vld[q.wr_idx[4:0]]) begin
                  d.arr_we = 1'b1;
                  d.arr_addr = {q.last_addr[15:5], q.wr_idx[4:0]};
                  d.arr_wdata = buf_data[q.wr_idx[4:0]];
               end
            end else if (q.timer == 16'h0000) begin
               d.st = S_READ;
            end
         end
         S_ABORT: if (wr && is_u1) d.st = S_AU1;
         S_AU1: if (wr) d.st = is_u2 ? S_AU2 : S_ABORT;
         S_AU2: if (wr) begin
            d.st = (bus.wr_addr == fbp_pkg::OFS_UNLOCK1 &&
                    bus.wr_data == fbp_pkg::CMD_ABORT_RESET) ?
                   S_READ : S_ABORT;
         end
         S_E1: if (wr) d.st = is_u1 ? S_E2 : S_READ;
         S_E2: if (wr) d.st = is_u2 ? S_E3 : S_READ;
         S_E3: if (wr) begin
            if (bus.wr_data == fbp_pkg::CMD_SECTOR_ERASE) begin
               d.st = S_EWIN;
               d.sec = bus.wr_addr;
               d.sec_mask = 4'h0;
               d.sec_mask[bus.wr_addr[13:12]] = 1'b1;
               d.timer = 16'(SEA_CYC);
            end else begin
               d.st = S_READ;
            end
         end
         S_EWIN: if (wr) begin
            if (bus.wr_data == fbp_pkg::CMD_SECTOR_ERASE) begin
               d.sec_mask[bus.wr_addr[13:12]] = 1'b1;
               d.timer = 16'(SEA_CYC);
            end else if (bus.wr_data == fbp_pkg::CMD_ERASE_SUSPEND) begin
               d.st = S_SUSP;
            end else begin
               d.st = S_READ;
            end
         end else if (q.timer == 16'h0000) begin
            d.st = S_ERASE;
            d.sec_idx = 4'h0;
            d.word = 12'h000;
            d.timer = 16'(ERASE_CYC);
         end
         S_ERASE: begin
            // Wipe each queued sector index of the first sector's bank word by word; FFFF after success
            if (wr && bus.wr_data == fbp_pkg::CMD_ERASE_SUSPEND) begin
               d.st = S_SUSP;
            end else if (q.sec_idx[2]) begin
               d.st = S_READ;
               d.sec_mask = 4'h0;
            end else begin
               if (q.sec_mask[q.sec_idx[1:0]]) begin
                  d.arr_we = 1'b1;
                  d.arr_addr = {q.sec[15:14], q.sec_idx[1:0], q.word};
                  d.arr_wdata = fbp_pkg::ERASED_WORD;
                  d.word = q.word + 12'h001;
               end
               if (q.timer == 16'h0000 &&
                   (q.word == 12'hfff || !q.sec_mask[q.sec_idx[1:0]])) begin
                  d.sec_idx = q.sec_idx + 4'h1;
                  d.timer = 16'(ERASE_CYC);
               end
            end
         end
         // Suspend parks the erase; only the reset command leaves it, back to read
         S_SUSP: if (wr && bus.wr_data == fbp_pkg::CMD_ABORT_RESET) begin
            d.st = S_READ;
         end
         default: d.st = S_READ;
      endcase
      d.busy = d.st == S_PROG || d.st == S_ERASE;
      d.aborted = d.st == S_ABORT;

      // Read path
      if (rd) begin
         d.rd_valid = 1'b1;
         if (q.st == S_ABORT || q.st == S_AU1 || q.st == S_AU2) begin
            sts[fbp_pkg::STS_ABORT] = 1'b1;
            sts[fbp_pkg::STS_POLL] = ~q.last_data[7];
            sts[fbp_pkg::STS_TOGGLE] = q.toggle;
            d.toggle = ~q.toggle;
            d.rd_data = sts;
         end else if (q.st == S_PROG) begin
            sts[fbp_pkg::STS_POLL] = ~q.last_data[7];
            sts[fbp_pkg::STS_TOGGLE] = q.toggle;
            d.toggle = ~q.toggle;
            d.rd_data = sts;
         end else if ((q.st == S_EWIN || q.st == S_ERASE) && erase_bank) begin
            sts[fbp_pkg::STS_POLL] = 1'b0;
            sts[fbp_pkg::STS_TOGGLE] = q.toggle;
            sts[fbp_pkg::STS_ETOGGLE] = q.etoggle;
            sts[fbp_pkg::STS_TIMER] = q.st == S_ERASE;
            d.toggle = ~q.toggle;
            d.etoggle = ~q.etoggle;
            d.rd_data = sts;
         end else begin
            d.rd_data = arr_rdata;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign bus.wr_ready = q.wr_ready;
   assign bus.rd_valid = q.rd_valid;
   assign bus.rd_data = q.rd_data;
   assign arr_we = q.arr_we;
   assign arr_addr = q.arr_addr;
   assign arr_wdata = q.arr_wdata;
   assign busy = q.busy;
   assign aborted = q.aborted;
endmodule : fbp_dev

// ### fbp_host.sv
`timescale 1ns/1ps
module fbp_host #(
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Device side
   fbp_bus_if.host bus,
   // User write stream
   input wire logic u_valid,
   output logic u_ready,
   input wire logic [15:0] u_addr,
   input wire logic [15:0] u_data,
   // User read
   input wire logic u_rd,
   input wire logic [15:0] u_rd_addr,
   output logic u_rd_valid,
   output logic [15:0] u_rd_data
);
   initial begin
      if (DEPTH != 2) $error("fbp_host: only a two-entry buffer");
   end

   typedef struct packed {
      logic [1:0][31:0] ent;
      logic [1:0] cnt;
      logic rd_req;
      logic [15:0] rd_addr;
      logic rd_valid;
      logic [15:0] rd_data;
   } fbp_host_t;

   fbp_host_t q, d;
   logic push, pop;

   // Buffer lets the device stall a write without losing the word
   assign pop = q.cnt != 2'd0 && bus.wr_ready;
   assign push = u_valid && q.cnt != 2'd2;

   always_comb begin
      d = q;
      if (pop) begin
         d.ent[0] = q.ent[1];
      end
      if (push) begin
         d.ent[(pop ? q.cnt - 2'd1 : q.cnt) == 2'd0 ? 0 : 1] =
            {u_addr, u_data};
      end
      d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
      d.rd_req = u_rd;
      d.rd_addr = u_rd_addr;
      d.rd_valid = bus.rd_valid;
      d.rd_data = bus.rd_valid ? bus.rd_data : q.rd_data;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign bus.wr_valid = q.cnt != 2'd0;
   assign bus.wr_addr = q.ent[0][31:16];
   assign bus.wr_data = q.ent[0][15:0];
   assign bus.rd_req = q.rd_req;
   assign bus.rd_addr = q.rd_addr;
   assign u_ready = q.cnt != 2'd2;
   assign u_rd_valid = q.rd_valid;
   assign u_rd_data = q.rd_data;
endmodule : fbp_host

// ### fbp_chk.sv
`timescale 1ns/1ps
module fbp_chk #(
   parameter int PROG_CYC = fbp_pkg::PROG_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Write channel
   input wire logic wr_valid,
   input wire logic wr_ready,
   input wire logic [15:0] wr_addr,
   input wire logic [15:0] wr_data,
   // Read channel
   input wire logic rd_req,
   input wire logic rd_valid,
   input wire logic [15:0] rd_data
);
   // Stall length, bounded by a full page plus the program wait
   logic [7:0] low_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_q <= 8'h00;
      end else begin
         low_q <= wr_ready ? 8'h00 : low_q + 8'h01;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_rd_answer: assert property (rd_req |=> rd_valid)
      else $error("read not answered next cycle");
   a_rd_pulse: assert property (!rd_req |=> !rd_valid)
      else $error("read answer without request");
   a_rd_hold: assert property (!rd_valid |-> $stable(rd_data))
      else $error("read data moved without answer");
   a_ready_release: assert property ($rose(rst_n) |=> wr_ready)
      else $error("write ready low after reset");
   a_stall_min: assert property ($fell(wr_ready) |->
      !wr_ready [*4])
      else $error("program stall too short");
   a_stall_bound: assert property (int'(low_q) < 40 + PROG_CYC)
      else $error("program stall too long");
   a_wr_hold: assert property (wr_valid && !wr_ready |=>
      wr_valid && $stable(wr_addr) && $stable(wr_data))
      else $error("write request dropped or changed");
   a_confirm_stall: assert property (wr_valid && wr_ready &&
      wr_data == fbp_pkg::CMD_BUF_CONFIRM |=> !wr_ready)
      else $error("confirm did not start programming");
endmodule : fbp_chk

// ### tb_flash_buffer_program_sector_erase.sv
`timescale 1ns/1ps
module tb_flash_buffer_program_sector_erase;
   localparam logic [15:0] INIT = 16'h1234;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic u_valid = 1'b0;
   logic [15:0] u_addr = 16'h0000;
   logic [15:0] u_data = 16'h0000;
   logic u_rd = 1'b0;
   logic [15:0] u_rd_addr = 16'h0000;
   logic u_ready, u_rd_valid, arr_we, busy, aborted;
   logic [15:0] u_rd_data, arr_addr, arr_wdata, arr_rdata;
   logic [15:0] mem [0:65535];
   logic [15:0] log_a[$];
   logic [15:0] log_d[$];
   int miscompares = 0;
   int comparisons = 0;
   always #20 clk = ~clk;
   fbp_bus_if bus ();
   fbp_host u_fbp_host (.clk(clk), .rst_n(rst_n), .bus(bus.host),
      .u_valid(u_valid), .u_ready(u_ready), .u_addr(u_addr),
      .u_data(u_data), .u_rd(u_rd), .u_rd_addr(u_rd_addr),
      .u_rd_valid(u_rd_valid), .u_rd_data(u_rd_data));
   fbp_dev #(.SEA_CYC(8), .PROG_CYC(4), .ERASE_CYC(4)) u_fbp_dev (
      .clk(clk), .rst_n(rst_n), .bus(bus.dev), .arr_we(arr_we),
      .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata),
      .busy(busy), .aborted(aborted));
   fbp_chk #(.PROG_CYC(4)) u_fbp_chk (.clk(clk), .rst_n(rst_n),
      .wr_valid(bus.wr_valid), .wr_ready(bus.wr_ready),
      .wr_addr(bus.wr_addr), .wr_data(bus.wr_data), .rd_req(bus.rd_req),
      .rd_valid(bus.rd_valid), .rd_data(bus.rd_data));
   // Array model and wire log of taken writes
   assign arr_rdata = mem[bus.rd_addr];
   always @(posedge clk) begin
      if (arr_we === 1'b1) mem[arr_addr] <= arr_wdata;
      if (bus.wr_valid === 1'b1 && bus.wr_ready === 1'b1) begin
         log_a.push_back(bus.wr_addr);
         log_d.push_back(bus.wr_data);
      end
   end
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic end_of_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   // Valid stays up between back-to-back writes; idle drops it
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      u_valid <= 1'b1;
      u_addr <= a;
      u_data <= d;
      do @(posedge clk); while (u_ready !== 1'b1);
   endtask : wr
   task automatic idle(input int k);
      u_valid <= 1'b0;
      repeat (k) @(posedge clk);
   endtask : idle
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      u_rd <= 1'b1;
      u_rd_addr <= a;
      @(posedge clk);
      u_rd <= 1'b0;
      do @(posedge clk); while (u_rd_valid !== 1'b1);
      d = u_rd_data;
   endtask : rd
   task automatic unlock();
      wr(fbp_pkg::OFS_UNLOCK1, fbp_pkg::CMD_UNLOCK1);
      wr(fbp_pkg::OFS_UNLOCK2, fbp_pkg::CMD_UNLOCK2);
   endtask : unlock
   task automatic wait_done();
      do @(posedge clk); while (busy !== 1'b0);
   endtask : wait_done
   task automatic prog(input logic [15:0] base, input int n);
      logic [15:0] r;
      log_a.delete();
      log_d.delete();
      unlock();
      wr(base, fbp_pkg::CMD_BUF_LOAD);
      wr(base, 16'(n - 1));
      for (int i = 0; i < n; i++) wr(base + 16'(i), ~(base + 16'(i)));
      wr(base, fbp_pkg::CMD_BUF_CONFIRM);
      idle(3);
      check("busy", 16'(busy), 16'h0001);
      wait_done();
      check("writes", 16'(log_a.size()), 16'(n + 5));
      check("unlock1", log_d[0], fbp_pkg::CMD_UNLOCK1);
      check("unlock2", log_a[1], fbp_pkg::OFS_UNLOCK2);
      check("loadcmd", log_d[2], fbp_pkg::CMD_BUF_LOAD);
      check("count", log_d[3], 16'(n - 1));
      check("confirm", log_d[n + 4], fbp_pkg::CMD_BUF_CONFIRM);
      for (int i = 0; i < n; i++) begin
         check("array", mem[base + 16'(i)], ~(base + 16'(i)));
      end
      rd(base + 16'(n - 1), r);
      check("readback", r, ~(base + 16'(n - 1)));
   endtask : prog
   task automatic clear_abort();
      unlock();
      wr(fbp_pkg::OFS_UNLOCK1, fbp_pkg::CMD_ABORT_RESET);
      idle(3);
      check("cleared", 16'(aborted), 16'h0000);
   endtask : clear_abort
   task automatic abort_page();
      logic [15:0] r1, r2;
      unlock();
      wr(16'h8000, fbp_pkg::CMD_BUF_LOAD);
      wr(16'h8000, 16'h0001);
      wr(16'h8000, 16'h1357);
      wr(16'h8040, 16'h2468);
      idle(3);
      check("abort page", 16'(aborted), 16'h0001);
      rd(16'h8000, r1);
      rd(16'h8000, r2);
      check("abort bits", 16'({r1[7], r1[5], r1[1]}), 16'h0005);
      check("abort toggle", 16'(r1[6] ^ r2[6]), 16'h0001);
      clear_abort();
      unlock();
      wr(16'h8000, fbp_pkg::CMD_BUF_LOAD);
      wr(16'h8000, 16'h0020);
      idle(3);
      check("abort count", 16'(aborted), 16'h0001);
      clear_abort();
   endtask : abort_page
   task automatic bad_prefix();
      wr(fbp_pkg::OFS_UNLOCK1, fbp_pkg::CMD_UNLOCK1);
      wr(16'h02ab, fbp_pkg::CMD_UNLOCK2);
      wr(16'h9000, fbp_pkg::CMD_BUF_LOAD);
      wr(16'h9000, 16'h0000);
      wr(16'h9000, 16'h1111);
      idle(4);
      check("prefix busy", 16'(busy | aborted), 16'h0000);
      check("prefix array", mem[16'h9000], INIT);
   endtask : bad_prefix
   task automatic erase(input logic [15:0] sec);
      unlock();
      wr(fbp_pkg::OFS_UNLOCK1, fbp_pkg::CMD_ERASE_SETUP);
      unlock();
      wr(sec, fbp_pkg::CMD_SECTOR_ERASE);
   endtask : erase
   task automatic erase_run();
      logic [15:0] r;
      erase(16'hc000);
      wr(16'hd000, fbp_pkg::CMD_SECTOR_ERASE);
      idle(1);
      rd(16'hc000, r);
      check("timer", 16'(r[fbp_pkg::STS_TIMER]), 16'h0000);
      check("erase poll", 16'(r[fbp_pkg::STS_POLL]), 16'h0000);
      rd(16'h0000, r);
      check("other bank", r, INIT);
      repeat (12) @(posedge clk);
      rd(16'hc000, r);
      check("timer out", 16'(r[fbp_pkg::STS_TIMER]), 16'h0001);
      wait_done();
      rd(16'hc000, r);
      check("erased c", r, fbp_pkg::ERASED_WORD);
      check("erased c end", mem[16'hcfff], fbp_pkg::ERASED_WORD);
      rd(16'hd000, r);
      check("erased d", r, fbp_pkg::ERASED_WORD);
      check("kept e", mem[16'he000], INIT);
      erase(16'h2000);
      wr(fbp_pkg::OFS_UNLOCK1, fbp_pkg::CMD_ABORT_RESET);
      idle(20);
      wait_done();
      check("abandoned", mem[16'h2000], INIT);
   endtask : erase_run
   task automatic reset_mid();
      erase(16'h3000);
      idle(12);
      wr(fbp_pkg::OFS_UNLOCK1, fbp_pkg::CMD_UNLOCK1);
      idle(3);
      check("erase ignores", 16'(busy), 16'h0001);
      rst_n <= 1'b0;
      @(posedge clk);
      check("reset busy", 16'(busy), 16'h0000);
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      prog(16'h3000, 2);
      erase(16'h3000);
      idle(12);
      wr(16'h3000, fbp_pkg::CMD_ERASE_SUSPEND);
      idle(3);
      check("suspended", 16'(busy), 16'h0000);
      wr(fbp_pkg::OFS_UNLOCK1, fbp_pkg::CMD_ABORT_RESET);
      idle(2);
      prog(16'h3040, 1);
   endtask : reset_mid
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = INIT;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      prog(16'h4000, 1);
      prog(16'h4020, 32);
      abort_page();
      bad_prefix();
      erase_run();
      reset_mid();
      end_of_test();
   end
   // Full sector sweeps make the run about nine thousand cycles
   initial begin
      #(40 * 20000);
      miscompares++;
      end_of_test();
   end
endmodule : tb_flash_buffer_program_sector_erase
